// [link_control_pkg.sv]
package link_control_pkg;

    // Register placement and width.
    localparam logic [11:0] LINK_CONTROL_OFFSET   = 12'h050;
    localparam int          REG_WIDTH             = 16;

    // Field positions.
    localparam int          ACTIVE_STATE_POWER_CTL_LSB              = 0;
    localparam int          RSVD_BIT              = 2;
    localparam int          RCB_BIT               = 3;
    localparam int          LINK_DISABLE_BIT      = 4;
    localparam int          RETRAIN_BIT           = 5;
    localparam int          COMMON_CLK_BIT        = 6;

    // Power management control encodings.
    localparam logic [1:0]  ACTIVE_STATE_POWER_CTL_DISABLED         = 2'h0;
    localparam logic [1:0]  ACTIVE_STATE_POWER_CTL_L0S              = 2'h1;
    localparam logic [1:0]  ACTIVE_STATE_POWER_CTL_L1               = 2'h2;
    localparam logic [1:0]  ACTIVE_STATE_POWER_CTL_L0S_L1           = 2'h3;

    // Reset values.
    localparam logic [1:0]  ACTIVE_STATE_POWER_CTL_RESET            = 2'h0;
    localparam logic        LINK_DISABLE_RESET    = 1'h0;
    localparam logic        COMMON_CLK_RESET      = 1'h0;

    // Upstream retrain delay: 1 ms at 100 MHz.
    localparam int          CLOCK_MHZ             = 100;
    localparam int          RETRAIN_DELAY_US      = 1000;
    localparam int          RETRAIN_DELAY_CYCLES  = RETRAIN_DELAY_US * CLOCK_MHZ;

endpackage

// [link_control_register.sv]
module link_control_register #(
    parameter bit          IS_UPSTREAM          = 1'b0,
    parameter int unsigned RETRAIN_DELAY_CYCLES = link_control_pkg::RETRAIN_DELAY_CYCLES
) (
    input  wire logic        i_clock,
    input  wire logic        i_rst_b,
    input  wire logic        i_cfg_write,
    input  wire logic        i_cfg_read,
    input  wire logic [11:0] i_cfg_addr,
    input  wire logic [15:0] i_cfg_wdata,
    input  wire logic [1:0]  i_cfg_byte_en,
    input  wire logic        i_eeprom_load,
    input  wire logic [1:0]  i_eeprom_active_state_power_ctl,
    input  wire logic        i_upstream_unlock,
    input  wire logic        i_ltssm_in_recovery,
    input  wire logic        i_ltssm_in_config,
    output logic      [15:0] o_cfg_rdata,
    output logic             o_cfg_hit,
    output logic             o_cfg_write_done,
    output logic             o_retrain_request,
    output logic             o_link_training_flag,
    output logic             o_link_disable,
    output logic             o_tx_l0s_enable,
    output logic             o_rx_l0s_enable,
    output logic             o_l1_enable,
    output logic      [1:0]  o_active_state_power_ctl,
    output logic      [1:0]  o_applied_power_ctl,
    output logic             o_common_refclk_flag,
    output logic             o_retrain_pending
);

    ////////////////////////////////////////////////////////////////////////////
    // Stored fields and retrain machinery.

    typedef enum logic [2:0] {
        RT_IDLE  = 3'b001,
        RT_DELAY = 3'b010,
        RT_FIRE  = 3'b100
    } retrain_state_e;

    localparam int CNT_W = $clog2(RETRAIN_DELAY_CYCLES + 1);

    logic [1:0]       active_state_power_ctl_reg;
    logic             link_disable_reg;
    logic             common_clk_reg;
    logic [1:0]       applied_active_state_power_ctl_reg;
    logic             deferred_reg;
    logic [CNT_W-1:0] delay_cnt_reg;
    retrain_state_e   rt_state_reg;
    retrain_state_e   rt_state_next;
    logic             retrain_pulse_reg;
    logic             training_flag_reg;
    logic             write_done_reg;
    logic [15:0]      rdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of configuration accesses.

    wire addr_hit    = (i_cfg_addr == link_control_pkg::LINK_CONTROL_OFFSET);
    wire low_write   = i_cfg_write && addr_hit && i_cfg_byte_en[0];
    wire retrain_wr  = low_write && i_cfg_wdata[link_control_pkg::RETRAIN_BIT];
    wire retrain_ok  = !IS_UPSTREAM || i_upstream_unlock;
    wire retrain_go  = retrain_wr && retrain_ok;
    wire in_training = i_ltssm_in_recovery || i_ltssm_in_config;
    wire [1:0] active_state_power_ctl_wr_value = i_cfg_wdata[link_control_pkg::ACTIVE_STATE_POWER_CTL_LSB +: 2];

    // Read image: reserved, boundary and retrain bits read zero.
    wire [15:0] read_image = {9'h000,
                              common_clk_reg,
                              1'b0,
                              link_disable_reg,
                              1'b0,
                              1'b0,
                              active_state_power_ctl_reg};

    ////////////////////////////////////////////////////////////////////////////
    // Software-writable fields; only the low byte holds live bits.

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            active_state_power_ctl_reg         <= link_control_pkg::ACTIVE_STATE_POWER_CTL_RESET;
            link_disable_reg <= link_control_pkg::LINK_DISABLE_RESET;
            common_clk_reg   <= link_control_pkg::COMMON_CLK_RESET;
        end else if (low_write) begin
            active_state_power_ctl_reg         <= active_state_power_ctl_wr_value;
            link_disable_reg <= i_cfg_wdata[link_control_pkg::LINK_DISABLE_BIT];
            common_clk_reg   <= i_cfg_wdata[link_control_pkg::COMMON_CLK_BIT];
        end else if (i_eeprom_load) begin
            active_state_power_ctl_reg         <= i_eeprom_active_state_power_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Training-relevant settings reach the link at once, or wait until the machine
    // leaves training when it is already in Recovery or Configuration.

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            applied_active_state_power_ctl_reg <= link_control_pkg::ACTIVE_STATE_POWER_CTL_RESET;
            deferred_reg     <= 1'b0;
        end else if (retrain_go && in_training) begin
            deferred_reg     <= 1'b1;
        end else if (retrain_go || (deferred_reg && !in_training)) begin
            applied_active_state_power_ctl_reg <= low_write ? active_state_power_ctl_wr_value : active_state_power_ctl_reg;
            deferred_reg     <= 1'b0;
        end else if (!in_training) begin
            applied_active_state_power_ctl_reg <= active_state_power_ctl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Retrain sequencer: immediate on downstream, 1 ms delayed on upstream.

    always_comb begin
        rt_state_next = rt_state_reg;
        case (rt_state_reg)
            RT_IDLE: begin
                if (retrain_go) begin
                    rt_state_next = IS_UPSTREAM ? RT_DELAY : RT_FIRE;
                end
            end
            RT_DELAY: begin
                if (delay_cnt_reg == CNT_W'(RETRAIN_DELAY_CYCLES - 1)) begin
                    rt_state_next = RT_FIRE;
                end
            end
            RT_FIRE: begin
                rt_state_next = RT_IDLE;
            end
            default: begin
                rt_state_next = RT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            rt_state_reg      <= RT_IDLE;
            delay_cnt_reg     <= '0;
            retrain_pulse_reg <= 1'b0;
        end else begin
            rt_state_reg      <= rt_state_next;
            delay_cnt_reg     <= (rt_state_reg == RT_DELAY) ? delay_cnt_reg + 1'b1 : '0;
            retrain_pulse_reg <= (rt_state_next == RT_FIRE);
        end
    end

    // Training flag rises with the retrain pulse and falls when the link leaves training.
    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            training_flag_reg <= 1'b0;
        end else if (rt_state_next == RT_FIRE) begin
            training_flag_reg <= 1'b1;
        end else if (!in_training && rt_state_reg == RT_IDLE && !retrain_pulse_reg) begin
            training_flag_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data and write completion; the completion never waits for the delay.

    always_ff @(posedge i_clock) begin
        if (!i_rst_b) begin
            rdata_reg      <= 16'h0000;
            write_done_reg <= 1'b0;
        end else begin
            rdata_reg      <= (i_cfg_read && addr_hit) ? read_image : 16'h0000;
            write_done_reg <= i_cfg_write && addr_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs toward the link layer.

    assign o_cfg_rdata              = rdata_reg;
    assign o_cfg_hit                = addr_hit;
    assign o_cfg_write_done         = write_done_reg;
    assign o_retrain_request        = retrain_pulse_reg;
    assign o_link_training_flag     = training_flag_reg;
    assign o_link_disable           = !IS_UPSTREAM && link_disable_reg;
    assign o_tx_l0s_enable          = applied_active_state_power_ctl_reg[0];
    assign o_rx_l0s_enable          = 1'b1;
    assign o_l1_enable              = applied_active_state_power_ctl_reg[1];
    assign o_active_state_power_ctl = active_state_power_ctl_reg;
    assign o_applied_power_ctl      = applied_active_state_power_ctl_reg;
    assign o_common_refclk_flag     = common_clk_reg;
    assign o_retrain_pending        = deferred_reg || (rt_state_reg == RT_DELAY);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_retrain_accepted;
        rt_state_reg == RT_IDLE && retrain_go;
    endsequence

    a_down_retrain_now: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (!IS_UPSTREAM and s_retrain_accepted) |=> o_retrain_request)
        else $error("Downstream retrain did not fire next cycle.");

    a_up_retrain_late: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        (IS_UPSTREAM and s_retrain_accepted) |=> !o_retrain_request [*8])
        else $error("Upstream retrain fired before its delay.");

    a_locked_no_retrain: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        IS_UPSTREAM && !i_upstream_unlock && rt_state_reg == RT_IDLE |=> rt_state_reg == RT_IDLE)
        else $error("Locked upstream port accepted a retrain.");

    a_flag_not_early: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        $rose(o_link_training_flag) |-> $rose(o_retrain_request) || rt_state_reg == RT_FIRE)
        else $error("Training flag rose without a retrain.");

    a_read_zero_bits: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        o_cfg_rdata[5:2] == 4'h0 || o_cfg_rdata[5:2] == 4'h4)
        else $error("Retrain, boundary or reserved bit read nonzero.");

    a_write_completes: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        i_cfg_write && addr_hit |=> o_cfg_write_done)
        else $error("Write completion not sent next cycle.");

    a_disable_follows: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        low_write |=> o_link_disable == (!IS_UPSTREAM && $past(i_cfg_wdata[link_control_pkg::LINK_DISABLE_BIT])))
        else $error("Link disable does not follow the written bit.");

    a_fields_both: assert property (@(posedge i_clock) disable iff (!i_rst_b)
        retrain_wr |=> o_active_state_power_ctl == $past(active_state_power_ctl_wr_value))
        else $error("Power field not updated with retrain write.");

endmodule

// [ltssm_model.sv]
// Training state machine stand-in: Recovery, then Configuration, then back to the normal link state.
module ltssm_model (
    input  wire logic i_clock,
    input  wire logic i_rst_b,
    input  wire logic i_retrain,
    input  wire logic i_hold,
    output logic      o_in_recovery,
    output logic      o_in_config
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] step_reg;
    ////////////////////////////////////////////////////////////////////////////////
    // Steps 8 to 5 are Recovery and 4 to 1 Configuration; holding keeps it in Recovery (slow answer).
    always_ff @(posedge i_clock) begin
        if (!i_rst_b)
            step_reg <= 4'h0;
        else if (i_retrain || i_hold)
            step_reg <= 4'h8;
        else if (step_reg != 4'h0)
            step_reg <= step_reg - 4'h1;
    end
    // State levels seen by the register block.
    assign o_in_recovery = (step_reg > 4'h4);
    assign o_in_config   = (step_reg != 4'h0) && (step_reg < 4'h5);
endmodule

// [link_control_register_tb.sv]
// Self-checking bench: a downstream and an upstream copy share one configuration bus.
module link_control_register_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DLY = 20;
    logic        clk;
    logic        rst_b = 1'b0, wr = 1'b0, rd = 1'b0, ee_load = 1'b0, unlock = 1'b0, hold = 1'b0;
    logic        rt_free = 1'b0, rd_seen = 1'b0, rec, cfgst, rt, tflag, lnk_off, txl0s, rxl0s, l1;
    logic        up_rt, up_tflag, up_lnk_off, up_wdone, common_refclk_flag, wdone, up_pend;
    logic [11:0] addr = 12'h000;
    logic [15:0] wdata = 16'h0000, rdata, d;
    logic [1:0]  be = 2'h0, ee_active_state_power_ctl = 2'h0, applied, pwr_ctl;
    int          cyc = 0, error_cnt = 0, checked = 0;
    logic [15:0] rd_q[$];
    int          rt_q[$], up_q[$];
    ////////////////////////////////////////////////////////////////////////////////
    // Both copies and the training machine stand-in.
    link_control_register #(.IS_UPSTREAM(1'b0), .RETRAIN_DELAY_CYCLES(DLY)) dut (
        .i_clock(clk), .i_rst_b(rst_b), .i_cfg_write(wr), .i_cfg_read(rd), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .i_cfg_byte_en(be), .i_eeprom_load(ee_load), .i_eeprom_active_state_power_ctl(ee_active_state_power_ctl),
        .i_upstream_unlock(unlock), .i_ltssm_in_recovery(rec), .i_ltssm_in_config(cfgst),
        .o_cfg_rdata(rdata), .o_cfg_hit(), .o_cfg_write_done(wdone), .o_retrain_request(rt),
        .o_link_training_flag(tflag), .o_link_disable(lnk_off), .o_tx_l0s_enable(txl0s),
        .o_rx_l0s_enable(rxl0s), .o_l1_enable(l1), .o_active_state_power_ctl(pwr_ctl),
        .o_applied_power_ctl(applied), .o_common_refclk_flag(common_refclk_flag), .o_retrain_pending());
    link_control_register #(.IS_UPSTREAM(1'b1), .RETRAIN_DELAY_CYCLES(DLY)) up_dut (
        .i_clock(clk), .i_rst_b(rst_b), .i_cfg_write(wr), .i_cfg_read(rd), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .i_cfg_byte_en(be), .i_eeprom_load(ee_load), .i_eeprom_active_state_power_ctl(ee_active_state_power_ctl),
        .i_upstream_unlock(unlock), .i_ltssm_in_recovery(1'b0), .i_ltssm_in_config(1'b0),
        .o_cfg_rdata(), .o_cfg_hit(), .o_cfg_write_done(up_wdone), .o_retrain_request(up_rt),
        .o_link_training_flag(up_tflag), .o_link_disable(up_lnk_off), .o_tx_l0s_enable(),
        .o_rx_l0s_enable(), .o_l1_enable(), .o_active_state_power_ctl(),
        .o_applied_power_ctl(), .o_common_refclk_flag(), .o_retrain_pending(up_pend));
    ltssm_model lm (.i_clock(clk), .i_rst_b(rst_b), .i_retrain(rt), .i_hold(hold),
        .o_in_recovery(rec), .o_in_config(cfgst));
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle count and note of reads taken.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        rd_seen <= rd;
    end
    // The oldest note is taken whenever a result shows, except a downstream pulse while rt_free is set; a pulse with no note gets -1.
    always @(negedge clk) begin
        if (rd_seen)
            chk_val(rdata, rd_q.pop_front());
        if (rt && !rt_free)
            chk_cyc(rt_q.size() > 0 ? rt_q.pop_front() : -1);
        if (up_rt)
            chk_cyc(up_q.size() > 0 ? up_q.pop_front() : -1);
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_cyc(input int exp);
        checked++;
        if (cyc !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, cyc, exp);
        end
    endtask
    task automatic cfg_write(input logic [11:0] a, input logic [15:0] v, input logic [1:0] b);
        @(negedge clk);
        wr = 1'b1;
        addr = a;
        wdata = v;
        be = b;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic cfg_read(input logic [11:0] a, input logic [15:0] exp);
        @(negedge clk);
        rd = 1'b1;
        addr = a;
        rd_q.push_back(exp);
        @(negedge clk);
        rd = 1'b0;
    endtask
    // Bounded wait until training is over on the downstream side.
    task automatic wait_idle();
        int n;
        n = 0;
        while ((tflag !== 1'b0 || rec !== 1'b0 || cfgst !== 1'b0) && n < 100) begin
            @(negedge clk);
            n++;
        end
        if (n == 100) begin
            error_cnt++;
            end_of_test();
        end
    endtask
    task automatic end_of_test();
        if (error_cnt == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard.
    initial begin
        #200us;
        error_cnt++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        void'($urandom(32'h0490));
        repeat (20) @(negedge clk);
        rst_b = 1'b1;
        cfg_read(12'h050, 16'h0000);
        ee_active_state_power_ctl = 2'h2;
        ee_load = 1'b1;
        @(negedge clk);
        ee_load = 1'b0;
        cfg_read(12'h050, 16'h0002);
        for (int code = 0; code < 4; code++) begin
            d = (16'($urandom) & 16'hffdc) | 16'(code);
            cfg_write(12'h050, d, 2'h1);
            cfg_write(12'h054, ~d, 2'h1);
            cfg_write(12'h050, ~d, 2'h2);
            cfg_read(12'h050, d & 16'h0053);
            cfg_read(12'h058, 16'h0000);
            chk_val({l1, txl0s}, code[1:0]);
            chk_val(rxl0s, 1'b1);
            chk_val({lnk_off, up_lnk_off}, {d[4], 1'b0});
            chk_val({common_refclk_flag, pwr_ctl}, {d[6], code[1:0]});
        end
        rt_q.push_back(cyc + 2);
        cfg_write(12'h050, 16'h0021, 2'h1);
        chk_val(wdone, 1'b1);
        repeat (2) @(negedge clk);
        chk_val(applied, 2'h1);
        cfg_read(12'h050, 16'h0001);
        wait_idle();
        hold = 1'b1;
        rt_free = 1'b1;
        repeat (2) @(negedge clk);
        cfg_write(12'h050, 16'h0023, 2'h1);
        repeat (3) @(negedge clk);
        chk_val(applied, 2'h1);
        hold = 1'b0;
        wait_idle();
        chk_val(applied, 2'h3);
        rt_free = 1'b0;
        rt_q.push_back(cyc + 2);
        cfg_write(12'h050, 16'h0020, 2'h1);
        repeat (DLY + 5) @(negedge clk);
        wait_idle();
        unlock = 1'b1;
        rt_q.push_back(cyc + 2);
        up_q.push_back(cyc + 2 + DLY);
        cfg_write(12'h050, 16'h0020, 2'h1);
        chk_val(up_wdone, 1'b1);
        repeat (DLY / 2) @(negedge clk);
        chk_val(up_tflag, 1'b0);
        chk_val(up_pend, 1'b1);
        repeat (DLY) @(negedge clk);
        chk_val(16'(rt_q.size() + up_q.size()), 16'h0000);
        end_of_test();
    end
endmodule
